// >>> design/usr_defines.vh
// Constants for the synchronous master receive path of the serial port.
// Assumes register indices sit on a word-aligned bus: byte address = 4 * index.
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH

// Register indices
`define USR_IDX_INT_CTRL 8'h0b
`define USR_IDX_FLAGS 8'h0c
`define USR_IDX_RX_STATUS 8'h18
`define USR_IDX_RX_DATA 8'h1a
`define USR_IDX_ENABLES 8'h8c
`define USR_IDX_TX_STATUS 8'h98
`define USR_IDX_BAUD 8'h99

// Receive status and control fields
`define USR_B_PORT_EN 7
`define USR_B_NINE_SEL 6
`define USR_B_SINGLE_EN 5
`define USR_B_CONT_EN 4
`define USR_B_OVERRUN 1
`define USR_B_NINTH 0

// Transmit status and control fields
`define USR_B_MASTER 7
`define USR_B_TX_EN 5
`define USR_B_SYNC_MODE 4

// Flag and enable fields
`define USR_B_RX_DONE 5
`define USR_B_RX_IE 5

// Writable masks and constant read bits
`define USR_RXS_WMASK 8'hf0
`define USR_TXS_WMASK 8'hf5
`define USR_TXS_SHIFT_EMPTY 8'h02

// Reset values
`define USR_RST_BYTE 8'h00
`define USR_RST_WORD 9'h000

// Last bit index of a word
`define USR_LAST_BIT_EIGHT 4'h7
`define USR_LAST_BIT_NINE 4'h8

// Bus constants
`define USR_HTRANS_ACTIVE 1
`define USR_HRESP_OKAY 1'b0

`endif

// >>> design/usr_sync_master_rx.v
// Synchronous master receive path of a serial port with AHB-Lite register access.
// Assumes one clock, a synchronous active-high reset and an external slave on the data line.
`timescale 1ns/10ps
`include "usr_defines.vh"

module usr_sync_master_rx (
	input wire clk_sys_in, // System clock, 100 MHz
	input wire rst_in, // Synchronous reset, active high
	input wire hsel_in, // AHB slave select
	input wire [31:0] haddr_in, // AHB address
	input wire [1:0] htrans_in, // AHB transfer type
	input wire hwrite_in, // AHB write strobe
	input wire [2:0] hsize_in, // AHB size, words only
	input wire [31:0] hwdata_in, // AHB write data
	input wire hready_in, // AHB bus ready
	output wire [31:0] hrdata_out, // AHB read data
	output wire hreadyout_out, // AHB slave ready
	output wire hresp_out, // AHB response, always OKAY
	input wire data_line_in, // Data pin level
	output wire data_line_out, // Data pin drive value
	output wire data_line_oe_out, // Data pin enable, never driven here
	output wire clock_line_out, // Shift clock level
	output wire clock_line_oe_out, // Shift clock enable
	output wire rx_irq_out, // Receive interrupt, active high
	output wire tx_hold_out // Holds the transmitter off while receiving
);

	// Register file
	// Only the receive side is modelled; transmit control is kept as plain
	// storage so that software sees the bits it wrote and the baud generator
	// can still be started from the transmit enable.
	reg [7:0] int_ctrl_reg;
	reg [7:0] enables_reg;
	reg [7:0] rx_ctrl_reg;
	reg [7:0] tx_ctrl_reg;
	reg [7:0] baud_reg;
	reg overrun_reg;
	reg [7:0] rx_ctrl_next;
	reg overrun_next;

	// Bus pipeline
	reg wr_pend_reg;
	reg [7:0] wr_idx_reg;
	reg [31:0] hrdata_reg;
	reg [7:0] rd_byte;

	// Pin synchroniser and filtered data level
	// The data pin is asynchronous to the system clock, so the level used by
	// the shifter lags the pin by three to four cycles; the shift clock half
	// period must stay longer than that for the sample to be meaningful.
	reg data_sync1_reg;
	reg data_sync2_reg;
	reg data_sync3_reg;
	reg data_level_reg;

	// Baud generator and shifter
	reg [7:0] baud_cnt_reg;
	reg clock_line_reg;
	reg [3:0] bit_cnt_reg;
	reg [8:0] shift_reg;

	// Two-entry receive FIFO
	// Each entry carries the ninth bit beside the data byte, so the status
	// register always shows the ninth bit of the word at the head.
	reg [8:0] fifo_mem_reg [0:1];
	reg fifo_wr_ptr_reg;
	reg fifo_rd_ptr_reg;
	reg [1:0] fifo_count_reg;

	wire bus_take;
	wire rd_take;
	wire [7:0] acc_idx;
	wire sync_master;
	wire single_en;
	wire cont_en;
	wire rx_active;
	wire baud_run;
	wire baud_tick;
	wire fall_edge;
	wire last_bit;
	wire word_done;
	wire push;
	wire pop;
	wire fifo_full;
	wire fifo_empty;
	wire [8:0] fifo_head;
	wire [3:0] last_idx;

	// Register index from a byte address
	function [7:0] word_index;
		input [31:0] addr;
		begin
			word_index = addr[9:2];
		end
	endfunction

	// Bit write with mask: keep unmasked bits, take masked bits from data
	function [7:0] masked_write;
		input [7:0] old_val;
		input [7:0] new_val;
		input [7:0] mask;
		begin
			masked_write = (old_val & ~mask) | (new_val & mask);
		end
	endfunction

	// Address phase acceptance
	// Zero wait states: a read is answered from a register loaded at the
	// address phase edge, a write lands at the end of its data phase.
	assign bus_take = hsel_in & htrans_in[`USR_HTRANS_ACTIVE] & hready_in;
	assign rd_take = bus_take & ~hwrite_in;
	assign acc_idx = word_index(haddr_in);

	// Mode decode
	assign sync_master = rx_ctrl_reg[`USR_B_PORT_EN] & tx_ctrl_reg[`USR_B_SYNC_MODE]
		& tx_ctrl_reg[`USR_B_MASTER];
	assign single_en = rx_ctrl_reg[`USR_B_SINGLE_EN];
	assign cont_en = rx_ctrl_reg[`USR_B_CONT_EN];
	assign rx_active = sync_master & (single_en | cont_en) & ~overrun_reg;
	assign baud_run = tx_ctrl_reg[`USR_B_TX_EN] | single_en | cont_en;
	assign baud_tick = baud_run & (baud_cnt_reg == `USR_RST_BYTE);

	// Shift sequencing
	// A high-to-low tick is the falling shift clock edge: the bit is taken
	// there, and on the last bit the word is complete in the same cycle.
	assign fall_edge = rx_active & baud_tick & clock_line_reg;
	assign last_idx = rx_ctrl_reg[`USR_B_NINE_SEL] ? `USR_LAST_BIT_NINE : `USR_LAST_BIT_EIGHT;
	assign last_bit = (bit_cnt_reg == last_idx);
	assign word_done = fall_edge & last_bit;

	// FIFO control
	assign fifo_full = fifo_count_reg[1];
	assign fifo_empty = (fifo_count_reg == 2'b00);
	assign fifo_head = fifo_mem_reg[fifo_rd_ptr_reg];
	assign push = word_done & ~fifo_full;
	assign pop = rd_take & (acc_idx == `USR_IDX_RX_DATA) & ~fifo_empty;

	// Outputs
	assign hrdata_out = hrdata_reg;
	assign hreadyout_out = 1'b1;
	assign hresp_out = `USR_HRESP_OKAY;
	assign data_line_out = 1'b0;
	assign data_line_oe_out = 1'b0;
	assign clock_line_out = clock_line_reg;
	assign clock_line_oe_out = sync_master;
	assign rx_irq_out = ~fifo_empty & enables_reg[`USR_B_RX_IE];
	assign tx_hold_out = rx_active;

	// Three-stage pin synchroniser; level follows once stages two and three agree
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			data_sync1_reg <= 1'b0;
			data_sync2_reg <= 1'b0;
			data_sync3_reg <= 1'b0;
			data_level_reg <= 1'b0;
		end
		else
		begin
			data_sync1_reg <= data_line_in;
			data_sync2_reg <= data_sync1_reg;
			data_sync3_reg <= data_sync2_reg;
			if (data_sync2_reg == data_sync3_reg)
				data_level_reg <= data_sync3_reg;
		end
	end

	// Baud counter: reloads from the divisor, held loaded with the divisor while idle
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
			baud_cnt_reg <= `USR_RST_BYTE;
		else if (!baud_run || baud_tick)
			baud_cnt_reg <= baud_reg;
		else
			baud_cnt_reg <= baud_cnt_reg - 8'h01;
	end

	// Shift clock and bit assembly; clock idles low between words
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			clock_line_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= `USR_RST_WORD;
		end
		else if (!rx_active)
		begin
			clock_line_reg <= 1'b0; // Abort any partial word
			bit_cnt_reg <= 4'h0;
		end
		else if (baud_tick)
		begin
			clock_line_reg <= ~clock_line_reg;
			if (clock_line_reg)
			begin
				shift_reg[bit_cnt_reg] <= data_level_reg;
				if (last_bit)
					bit_cnt_reg <= 4'h0;
				else
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Receive FIFO storage and pointers
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			fifo_mem_reg[0] <= `USR_RST_WORD;
			fifo_mem_reg[1] <= `USR_RST_WORD;
			fifo_wr_ptr_reg <= 1'b0;
			fifo_rd_ptr_reg <= 1'b0;
			fifo_count_reg <= 2'b00;
		end
		else
		begin
			if (push)
			begin
				// Last bit goes straight in with the assembled bits, ninth bit queued alongside
				fifo_mem_reg[fifo_wr_ptr_reg] <= rx_ctrl_reg[`USR_B_NINE_SEL] ?
					{data_level_reg, shift_reg[7:0]} :
					{1'b0, data_level_reg, shift_reg[6:0]};
				fifo_wr_ptr_reg <= ~fifo_wr_ptr_reg;
			end
			if (pop)
				fifo_rd_ptr_reg <= ~fifo_rd_ptr_reg;
			if (push && !pop)
				fifo_count_reg <= fifo_count_reg + 2'b01;
			else if (pop && !push)
				fifo_count_reg <= fifo_count_reg - 2'b01;
		end
	end

	// Next value of receive control: hardware self-clear, then software write
	always @*
	begin
		rx_ctrl_next = rx_ctrl_reg;
		if (word_done && !cont_en)
			rx_ctrl_next[`USR_B_SINGLE_EN] = 1'b0;
		if (wr_pend_reg && wr_idx_reg == `USR_IDX_RX_STATUS)
			rx_ctrl_next = masked_write(rx_ctrl_reg, hwdata_in[7:0], `USR_RXS_WMASK);
	end

	// Overrun: set on a lost word, cleared only by a clear continuous enable; set wins
	// While overrun stands, reception is gated off, so nothing else can reach
	// the FIFO until software drops the continuous enable to recover.
	always @*
	begin
		overrun_next = overrun_reg;
		if (!rx_ctrl_next[`USR_B_CONT_EN])
			overrun_next = 1'b0;
		if (word_done && fifo_full)
			overrun_next = 1'b1;
	end

	// Control registers and bus write pipeline
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
		begin
			int_ctrl_reg <= `USR_RST_BYTE;
			enables_reg <= `USR_RST_BYTE;
			rx_ctrl_reg <= `USR_RST_BYTE;
			tx_ctrl_reg <= `USR_RST_BYTE;
			baud_reg <= `USR_RST_BYTE;
			overrun_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= `USR_RST_BYTE;
		end
		else
		begin
			rx_ctrl_reg <= rx_ctrl_next;
			overrun_reg <= overrun_next;
			wr_pend_reg <= bus_take & hwrite_in;
			if (bus_take)
				wr_idx_reg <= acc_idx;
			if (wr_pend_reg)
			begin
				case (wr_idx_reg)
					`USR_IDX_INT_CTRL: int_ctrl_reg <= hwdata_in[7:0];
					`USR_IDX_ENABLES: enables_reg <= hwdata_in[7:0];
					`USR_IDX_TX_STATUS:
						tx_ctrl_reg <= masked_write(tx_ctrl_reg, hwdata_in[7:0], `USR_TXS_WMASK);
					`USR_IDX_BAUD: baud_reg <= hwdata_in[7:0];
					default: ;
				endcase
			end
		end
	end

	// Read multiplexer; flag and status reflect live FIFO state
	always @*
	begin
		case (acc_idx)
			`USR_IDX_INT_CTRL: rd_byte = int_ctrl_reg;
			`USR_IDX_FLAGS: rd_byte = {2'b00, ~fifo_empty, 5'b00000};
			`USR_IDX_RX_STATUS: rd_byte = {rx_ctrl_reg[7:4], 2'b00, overrun_reg,
				fifo_head[8] & ~fifo_empty};
			`USR_IDX_RX_DATA: rd_byte = fifo_head[7:0];
			`USR_IDX_ENABLES: rd_byte = enables_reg;
			`USR_IDX_TX_STATUS: rd_byte = (tx_ctrl_reg & `USR_TXS_WMASK) | `USR_TXS_SHIFT_EMPTY;
			`USR_IDX_BAUD: rd_byte = baud_reg;
			default: rd_byte = `USR_RST_BYTE;
		endcase
	end

	// Read data captured at the address phase, presented in the data phase
	always @(posedge clk_sys_in)
	begin
		if (rst_in)
			hrdata_reg <= 32'h00000000;
		else if (rd_take)
			hrdata_reg <= {24'h000000, rd_byte};
	end

endmodule

// >>> testbench/usr_slave_model.sv
// Far-side slave that shifts words onto the data line for the receive block.
// Assumes the master's shift clock idles low and samples on its falling edge.
`timescale 1ns/10ps
module usr_slave_model (
	input wire clk_sys_in, // System clock
	input wire clock_line_in, // Shift clock level on the wire
	input wire nine_in, // Nine bits per word
	input wire [8:0] word_in, // Next word to send
	output reg data_line_out, // Serial data to the master
	output reg loaded_out // Pulses when a word is taken
);
	reg [8:0] sh_reg = 9'h000;
	reg [3:0] cnt_reg = 4'h0;
	reg [3:0] hold_reg = 4'h0;
	reg ck_reg = 1'b0;
	initial data_line_out = 1'b0;
	initial loaded_out = 1'b0;
	// New bit after each rising clock, kept well past the falling edge
	always @(posedge clk_sys_in)
	begin
		ck_reg <= clock_line_in;
		loaded_out <= 1'b0;
		if (hold_reg == 4'h1)
			data_line_out <= ~data_line_out; // Hold time over: stop showing the last bit
		if (hold_reg != 4'h0)
			hold_reg <= hold_reg - 4'h1;
		if (clock_line_in && !ck_reg)
		begin
			hold_reg <= 4'h0;
			sh_reg <= (cnt_reg == 4'h0) ? word_in >> 1 : sh_reg >> 1;
			data_line_out <= (cnt_reg == 4'h0) ? word_in[0] : sh_reg[0];
			loaded_out <= (cnt_reg == 4'h0);
		end
		if (!clock_line_in && ck_reg)
		begin
			cnt_reg <= (cnt_reg == (nine_in ? 4'h8 : 4'h7)) ? 4'h0 : cnt_reg + 4'h1;
			hold_reg <= (cnt_reg == (nine_in ? 4'h8 : 4'h7)) ? 4'h6 : 4'h0;
		end
	end
endmodule

// >>> testbench/usr_rx_monitor.sv
// Port-level checks of the receive block.
// Assumes single AHB-Lite word transfers, mirrored here to follow the configuration.
`timescale 1ns/10ps
module usr_rx_monitor (
	input wire clk_sys_in, // System clock
	input wire rst_in, // Synchronous reset
	input wire hsel_in, // Bus select
	input wire [31:0] haddr_in, // Bus address
	input wire [1:0] htrans_in, // Transfer type
	input wire hwrite_in, // Write strobe
	input wire hready_in, // Bus ready
	input wire [31:0] hwdata_in, // Write data
	input wire data_line_oe_out, // Data pin enable
	input wire clock_line_out, // Shift clock
	input wire clock_line_oe_out, // Shift clock enable
	input wire rx_irq_out, // Receive interrupt
	input wire tx_hold_out // Reception active
);
	reg wv_reg, ie_reg, ms_reg, pe_reg, en_reg;
	reg [7:0] wi_reg;
	wire take_w = hsel_in && htrans_in[1] && hready_in;
	wire pop_w = take_w && !hwrite_in && haddr_in[9:2] == 8'h1a;
	// Mirror of the configuration bits written by software
	always @(posedge clk_sys_in)
	begin
		wv_reg <= !rst_in && take_w && hwrite_in;
		wi_reg <= haddr_in[9:2];
		if (rst_in)
			{ie_reg, ms_reg, pe_reg, en_reg} <= 4'h0;
		else if (wv_reg)
		begin
			if (wi_reg == 8'h8c)
				ie_reg <= hwdata_in[5];
			if (wi_reg == 8'h98)
				ms_reg <= hwdata_in[7] && hwdata_in[4];
			if (wi_reg == 8'h18)
				{pe_reg, en_reg} <= {hwdata_in[7], hwdata_in[5] || hwdata_in[4]};
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	chk_oe_config: assert property (clock_line_oe_out == (ms_reg && pe_reg))
		else $error("clock enable differs from configuration");
	chk_rx_start: assert property (tx_hold_out |-> clock_line_oe_out && en_reg)
		else $error("reception without enable");
	chk_clk_gate: assert property ($rose(clock_line_out) |-> tx_hold_out)
		else $error("shift clock rose outside reception");
	chk_irq_gate: assert property (rx_irq_out |-> ie_reg)
		else $error("interrupt while disabled");
	chk_idle_low: assert property (!tx_hold_out && $past(!tx_hold_out) |-> !clock_line_out)
		else $error("shift clock not low while idle");
	chk_data_hiz: assert property (!data_line_oe_out)
		else $error("data pin driven while receiving");
	chk_irq_hold: assert property ($fell(rx_irq_out) |-> $past(pop_w) || !ie_reg)
		else $error("interrupt dropped without a data read");
	chk_irq_rise: assert property ($rose(rx_irq_out) && $past(ie_reg) |->
		!clock_line_out && ($past(clock_line_out) || $past(clock_line_out, 2)))
		else $error("word completed away from a falling clock");
	cover property ($rose(rx_irq_out));
	cover property ($fell(tx_hold_out));
	cover property ($fell(rx_irq_out));
endmodule
bind usr_sync_master_rx usr_rx_monitor u_mon (.clk_sys_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
	.hwrite_in, .hready_in, .hwdata_in, .data_line_oe_out, .clock_line_out, .clock_line_oe_out,
	.rx_irq_out, .tx_hold_out);

// >>> testbench/tb_usart_sync_master_receive.sv
// Self-checking bench of the synchronous master receive block.
// Assumes the slave model drives the data line and a bus master reaches the registers.
`timescale 1ns/10ps
module tb_usart_sync_master_receive;
	reg clk_sys_in = 0, rst_in = 1, hsel_in = 1, hwrite_in = 0, rd_v = 0, nine = 0;
	reg [31:0] haddr_in = 0, hwdata_in = 0, rnd = 32'h2b3c22c5;
	reg [1:0] htrans_in = 0;
	reg [8:0] word_in = 9'h0c5, w0, w1;
	integer err_total = 0, samples_checked = 0;
	reg [15:0] exq[$];
	reg [8:0] sq[$];
	reg [15:0] note;
	wire [31:0] hrdata_out;
	wire hreadyout_out, hresp_out, dl_out, dl_oe, ck_out, ck_oe, rx_irq_out, tx_hold_out, sd, ld;
	usr_sync_master_rx dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'b010),
		.hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .data_line_in(dl_oe ? dl_out : sd),
		.data_line_out(dl_out), .data_line_oe_out(dl_oe), .clock_line_out(ck_out),
		.clock_line_oe_out(ck_oe), .rx_irq_out(rx_irq_out), .tx_hold_out(tx_hold_out));
	usr_slave_model u_slv (.clk_sys_in(clk_sys_in), .clock_line_in(ck_oe & ck_out), .nine_in(nine),
		.word_in(word_in), .data_line_out(sd), .loaded_out(ld));
	// Clock and watchdog
	initial forever #5 clk_sys_in = ~clk_sys_in;
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		err_total++;
		end_sim;
	end
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [8*5:1] nm, input [7:0] e, input [7:0] s);
		begin
			samples_checked++;
			if (s !== e)
			begin
				err_total++;
				$display("[ERR] %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	// One single transfer; a read notes its expected masked value
	task xfer(input [7:0] idx, input wr, input [7:0] wd, input [7:0] e, input [7:0] m);
		begin
			if (!wr)
				exq.push_back({m, e & m});
			haddr_in <= {22'h0, idx, 2'b00};
			htrans_in <= 2'b10;
			hwrite_in <= wr;
			@(posedge clk_sys_in);
			while (hreadyout_out !== 1'b1) @(posedge clk_sys_in);
			htrans_in <= 2'b00;
			hwdata_in <= {24'h0, wd};
			rd_v <= !wr;
			@(posedge clk_sys_in);
			while (hreadyout_out !== 1'b1) @(posedge clk_sys_in);
			rd_v <= 0;
		end
	endtask
	task idle;
		integer n;
		begin
			repeat (40) @(posedge clk_sys_in);
			for (n = 0; n < 3000 && tx_hold_out === 1'b1; n++) @(posedge clk_sys_in);
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Read results compared against the oldest note
	always @(posedge clk_sys_in)
		if (rd_v && hreadyout_out)
		begin
			note = exq.pop_front();
			chk("rdata", note[7:0], hrdata_out[7:0] & note[15:8]);
			chk("hresp", 8'h00, {7'h00, hresp_out});
		end
	// Words taken by the slave, next random word offered
	always @(posedge clk_sys_in)
		if (ld)
		begin
			sq.push_back(word_in);
			rnd = nx(rnd);
			word_in <= rnd[8:0];
		end
	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 0;
		@(posedge clk_sys_in);
		xfer(8'h98, 0, 0, 8'h02, 8'hff);
		xfer(8'h1a, 0, 0, 8'h00, 8'hff);
		xfer(8'h40, 0, 0, 8'h00, 8'hff);
		xfer(8'h0c, 1, 8'hff, 0, 0);
		xfer(8'h0c, 0, 0, 8'h00, 8'hff);
		xfer(8'h99, 1, 8'h07, 0, 0);
		xfer(8'h98, 1, 8'h90, 0, 0);
		xfer(8'h0b, 1, 8'hc0, 0, 0);
		xfer(8'h0b, 0, 0, 8'hc0, 8'hff);
		xfer(8'h18, 1, 8'ha0, 0, 0);
		idle;
		w0 = sq.pop_front();
		chk("irq", 8'h00, rx_irq_out);
		xfer(8'h0c, 0, 0, 8'h20, 8'hff);
		xfer(8'h8c, 1, 8'h20, 0, 0);
		xfer(8'h18, 0, 0, 8'h80, 8'hfe);
		chk("irq", 8'h01, rx_irq_out);
		xfer(8'h1a, 0, 0, w0[7:0], 8'hff);
		repeat (300) @(posedge clk_sys_in);
		xfer(8'h0c, 0, 0, 8'h00, 8'hff);
		$display("test 1 done");
		nine <= 1;
		xfer(8'h18, 1, 8'hd0, 0, 0);
		idle;
		w0 = sq.pop_front();
		w1 = sq.pop_front();
		xfer(8'h18, 0, 0, 8'hd2 | w0[8], 8'hff);
		xfer(8'h1a, 0, 0, w0[7:0], 8'hff);
		xfer(8'h18, 0, 0, 8'hd2 | w1[8], 8'hff);
		xfer(8'h1a, 0, 0, w1[7:0], 8'hff);
		repeat (300) @(posedge clk_sys_in);
		xfer(8'h0c, 0, 0, 8'h00, 8'hff);
		xfer(8'h18, 1, 8'hc0, 0, 0);
		xfer(8'h18, 0, 0, 8'hc0, 8'hff);
		$display("test 2 done");
		nine <= 0;
		sq.delete();
		xfer(8'h18, 1, 8'hb0, 0, 0);
		idle;
		xfer(8'h18, 0, 0, 8'hb2, 8'hfe);
		xfer(8'h18, 1, 8'h80, 0, 0);
		$display("test 3 done");
		end_sim;
	end
endmodule
